/* flash_reg_write.sv */
// Register-write command interpreter for a multi-I/O serial flash
`timescale 1ns/1ns
module flash_reg_write #(
   parameter int STATUS_WRITE_CYCLES = (flash_reg_pkg::STATUS_WRITE_TIME_NS +
      flash_reg_pkg::CLOCK_PERIOD_NS - 1) / flash_reg_pkg::CLOCK_PERIOD_NS,
   parameter int NV_CONFIG_WRITE_CYCLES = (flash_reg_pkg::NV_CONFIG_WRITE_TIME_NS +
      flash_reg_pkg::CLOCK_PERIOD_NS - 1) / flash_reg_pkg::CLOCK_PERIOD_NS
) (
   // System clock and reset
   input wire logic clock,
   input wire logic reset,
   // Serial link
   input wire logic sclk,
   input wire logic cs_n,
   input wire logic [3:0] dq_in,
   output logic [3:0] dq_out,
   output logic [3:0] dq_oe,
   // Pins and configuration
   input wire logic write_protect_n,
   input wire logic [1:0] io_mode,
   // Register view
   output logic [7:0] status_reg,
   output logic [7:0] flag_status,
   output logic [15:0] nv_config,
   output logic [7:0] v_config,
   output logic [7:0] ev_config,
   output logic [7:0] ext_addr,
   output logic write_busy,
   output logic hw_protected
);
   typedef enum logic {PHASE_IDLE, PHASE_TIMED} phase_t;

   typedef struct packed {
      logic [2:0] cs_sync;
      logic cs_level;
      logic [2:0] tog_sync;
      logic tog_level;
      logic tog_seen;
      logic [2:0] wp_sync;
      logic wp_level;
      phase_t phase;
      logic [31:0] timer;
      logic nv_pending;
      logic [15:0] nv_value;
      logic [7:0] sr;
      logic [7:0] fsr;
      logic [15:0] nvcr;
      logic [7:0] vcr;
      logic [7:0] evcr;
      logic [7:0] ear;
      logic [1:0] mode;
      logic link_reset;
      logic hw_prot;
   } sys_state_t;

   localparam sys_state_t SYS_RESET = '{
      cs_sync: 3'h7,
      cs_level: 1'b1,
      tog_sync: 3'h0,
      tog_level: 1'b0,
      tog_seen: 1'b0,
      wp_sync: 3'h7,
      wp_level: 1'b1,
      phase: PHASE_IDLE,
      timer: 32'h00000000,
      nv_pending: 1'b0,
      nv_value: 16'h0000,
      sr: flash_reg_pkg::SR_RESET,
      fsr: flash_reg_pkg::FSR_RESET,
      nvcr: flash_reg_pkg::NVCR_RESET,
      vcr: flash_reg_pkg::VCR_RESET,
      evcr: flash_reg_pkg::EVCR_RESET,
      ear: flash_reg_pkg::EAR_RESET,
      mode: 2'h0,
      link_reset: 1'b1,
      hw_prot: 1'b0
   };

   sys_state_t state_reg, state_next;
   link_bus_if bus ();

   link_shifter shifter (
      .sclk(sclk),
      .cs_n(cs_n),
      .dq_in(dq_in),
      .dq_out(dq_out),
      .dq_oe(dq_oe),
      .bus(bus.link)
   );

   assign bus.image = '{
      mode: state_reg.mode,
      sr: state_reg.sr,
      fsr: state_reg.fsr,
      nvcr: state_reg.nvcr,
      vcr: state_reg.vcr,
      evcr: state_reg.evcr,
      ear: state_reg.ear
   };
   assign bus.link_reset = state_reg.link_reset;

   assign status_reg = state_reg.sr;
   assign flag_status = state_reg.fsr;
   assign nv_config = state_reg.nvcr;
   assign v_config = state_reg.vcr;
   assign ev_config = state_reg.evcr;
   assign ext_addr = state_reg.ear;
   assign write_busy = state_reg.sr[flash_reg_pkg::SR_WIP_BIT];
   assign hw_protected = state_reg.hw_prot;

   always_comb begin
      logic frame_end;
      logic [4:0] count;
      logic [23:0] rx;
      logic [7:0] opcode;
      logic [7:0] data0;
      logic [7:0] data1;
      logic wel;
      frame_end = 1'b0;
      count = bus.rx_count;
      rx = bus.rx_data;
      opcode = 8'h00;
      data0 = 8'h00;
      data1 = 8'h00;
      wel = state_reg.sr[flash_reg_pkg::SR_WEL_BIT];
      state_next = state_reg;
      state_next.link_reset = 1'b0;
      state_next.mode = io_mode;

      // Pins from other domains: a change counts once stages two and three agree
      state_next.cs_sync = {state_reg.cs_sync[1:0], cs_n};
      state_next.tog_sync = {state_reg.tog_sync[1:0], bus.frame_toggle};
      state_next.wp_sync = {state_reg.wp_sync[1:0], write_protect_n};
      if (state_reg.cs_sync[1] == state_reg.cs_sync[2]) begin
         state_next.cs_level = state_reg.cs_sync[2];
      end
      if (state_reg.tog_sync[1] == state_reg.tog_sync[2]) begin
         state_next.tog_level = state_reg.tog_sync[2];
      end
      if (state_reg.wp_sync[1] == state_reg.wp_sync[2]) begin
         state_next.wp_level = state_reg.wp_sync[2];
      end
      // [RULE9] protect bit and pin gate status writes
      state_next.hw_prot = state_reg.sr[flash_reg_pkg::SR_PROTECT_BIT] & ~state_reg.wp_level;

      // Select without any clock edge leaves the toggle alone: no replay
      if (state_next.cs_level && !state_reg.cs_level && state_reg.tog_level != state_reg.tog_seen) begin
         frame_end = 1'b1;
         state_next.tog_seen = state_reg.tog_level;
      end

      // Shifter counts are stable here: the serial clock is idle after select rises
      if (count == flash_reg_pkg::BITS_TWO_BYTES) begin
         opcode = rx[23:16];
         data0 = rx[15:8];
         data1 = rx[7:0];
      end else if (count == flash_reg_pkg::BITS_ONE_BYTE) begin
         opcode = rx[15:8];
         data0 = rx[7:0];
      end else begin
         opcode = rx[7:0];
      end

      unique case (state_reg.phase)
         PHASE_IDLE: begin
            if (frame_end) begin
               unique case (opcode)
                  flash_reg_pkg::OP_WRITE_ENABLE: begin
                     // [RULE20] opcode framed alone sets latch
                     if (count == flash_reg_pkg::BITS_OPCODE) begin
                        state_next.sr[flash_reg_pkg::SR_WEL_BIT] = 1'b1;
                     end
                  end
                  flash_reg_pkg::OP_WRITE_DISABLE: begin
                     // Latch survives a pending protection error
                     if (count == flash_reg_pkg::BITS_OPCODE &&
                        !state_reg.fsr[flash_reg_pkg::FSR_PROT_ERR_BIT]) begin
                        state_next.sr[flash_reg_pkg::SR_WEL_BIT] = 1'b0;
                     end
                  end
                  flash_reg_pkg::OP_CLEAR_FLAGS: begin
                     if (count == flash_reg_pkg::BITS_OPCODE) begin
                        state_next.fsr = state_reg.fsr & ~flash_reg_pkg::FSR_ERROR_MASK;
                     end
                  end
                  flash_reg_pkg::OP_WRITE_STATUS: begin
                     // [RULE1] [RULE2] [RULE5] latch set, exact framing
                     if (wel && count == flash_reg_pkg::BITS_ONE_BYTE) begin
                        if (state_reg.hw_prot) begin
                           // [RULE9] protected: refused, latch kept
                           state_next.fsr[flash_reg_pkg::FSR_PROT_ERR_BIT] = 1'b1;
                        end else begin
                           // [RULE7] [RULE8] only bits seven to two
                           state_next.sr = (data0 & flash_reg_pkg::SR_WRITE_MASK) |
                              (state_reg.sr & ~flash_reg_pkg::SR_WRITE_MASK);
                           // [RULE6] [RULE10] [RULE11] timed, busy, latch cleared
                           state_next.sr[flash_reg_pkg::SR_WIP_BIT] = 1'b1;
                           state_next.sr[flash_reg_pkg::SR_WEL_BIT] = 1'b0;
                           state_next.fsr[flash_reg_pkg::FSR_READY_BIT] = 1'b0;
                           state_next.timer = 32'(STATUS_WRITE_CYCLES);
                           state_next.phase = PHASE_TIMED;
                        end
                     end
                  end
                  flash_reg_pkg::OP_WRITE_NV_CONFIG: begin
                     // [RULE3] [RULE15] two bytes, low byte first
                     if (wel && count == flash_reg_pkg::BITS_TWO_BYTES) begin
                        state_next.nv_value = {data1, data0};
                        state_next.nv_pending = 1'b1;
                        // [RULE6] [RULE10] [RULE11] timed, busy, latch cleared
                        state_next.sr[flash_reg_pkg::SR_WIP_BIT] = 1'b1;
                        state_next.sr[flash_reg_pkg::SR_WEL_BIT] = 1'b0;
                        state_next.fsr[flash_reg_pkg::FSR_READY_BIT] = 1'b0;
                        state_next.timer = 32'(NV_CONFIG_WRITE_CYCLES);
                        state_next.phase = PHASE_TIMED;
                     end
                  end
                  flash_reg_pkg::OP_WRITE_V_CONFIG: begin
                     if (wel && count == flash_reg_pkg::BITS_ONE_BYTE) begin
                        // [RULE16] [RULE17] immediate, reserved bits kept
                        state_next.vcr = (data0 & flash_reg_pkg::VCR_WRITE_MASK) |
                           (state_reg.vcr & ~flash_reg_pkg::VCR_WRITE_MASK);
                        state_next.sr[flash_reg_pkg::SR_WEL_BIT] = 1'b0;
                     end
                  end
                  flash_reg_pkg::OP_WRITE_EV_CONFIG: begin
                     // [RULE18] enhanced volatile write
                     if (wel && count == flash_reg_pkg::BITS_ONE_BYTE) begin
                        state_next.evcr = data0;
                        state_next.sr[flash_reg_pkg::SR_WEL_BIT] = 1'b0;
                     end
                  end
                  flash_reg_pkg::OP_WRITE_EXT_ADDR: begin
                     // [RULE18] extended address write
                     if (wel && count == flash_reg_pkg::BITS_ONE_BYTE) begin
                        state_next.ear = data0;
                        state_next.sr[flash_reg_pkg::SR_WEL_BIT] = 1'b0;
                     end
                  end
                  default: begin
                  end
               endcase
            end
         end
         PHASE_TIMED: begin
            // [RULE23] every write frame ignored while timed
            state_next.timer = state_reg.timer - 32'h00000001;
            if (state_reg.timer == 32'h00000001) begin
               // [RULE12] [RULE14] busy clears, ready flag returns
               state_next.sr[flash_reg_pkg::SR_WIP_BIT] = 1'b0;
               state_next.fsr[flash_reg_pkg::FSR_READY_BIT] = 1'b1;
               state_next.phase = PHASE_IDLE;
               state_next.nv_pending = 1'b0;
               if (state_reg.nv_pending) begin
                  state_next.nvcr = state_reg.nv_value;
               end
            end
         end
      endcase
   end

   always_ff @(posedge clock) begin
      if (reset) begin
         state_reg <= SYS_RESET;
      end else begin
         state_reg <= state_next;
      end
   end
endmodule

/* flash_reg_pkg.sv */
// Constants and types for the serial flash register-write block
// Overview of operation
// [RULE1] Host sets write enable before register writes
// [RULE2] Host holds select through last data bit
// [RULE3] Nonvolatile config write: select held sixteen bits
// [RULE4] Bits on one, two or four lines
// [RULE5] Misframed command discarded, latch and errors kept
// [RULE6] Status and nonvolatile writes are self-timed
// [RULE7] Status write updates bits seven to two
// [RULE8] Status write never touches bits one, zero
// [RULE9] Protect bit plus write-protect pin block writes; the code blocks only status writes
// [RULE10] Write-in-progress reads one during timed write
// [RULE11] Timed write clears write enable latch
// [RULE12] Write-in-progress clears when timed write ends
// [RULE13] Host polls flag status once per die
// [RULE14] Controller-ready flag returns one at completion
// [RULE15] Nonvolatile config data: two bytes, low first
// [RULE16] Volatile config write takes effect immediately
// [RULE17] Volatile config reserved bits stay unchanged
// [RULE18] Decode enhanced volatile and extended address writes
// [RULE19] Nonvolatile config read sends low byte first
// [RULE20] Framed write-enable opcode sets the latch
// [RULE21] Flag status read accepted at any time
// [RULE22] Most significant bit first, rising edge sampled
// [RULE23] Timed write in progress ignores register writes
package flash_reg_pkg;
   // Timing
   localparam int CLOCK_PERIOD_NS = 40;
   localparam int STATUS_WRITE_TIME_NS = 1000000;
   localparam int NV_CONFIG_WRITE_TIME_NS = 2000000;
   // Opcodes
   localparam logic [7:0] OP_WRITE_ENABLE = 8'h06;
   localparam logic [7:0] OP_WRITE_DISABLE = 8'h04;
   localparam logic [7:0] OP_CLEAR_FLAGS = 8'h50;
   localparam logic [7:0] OP_WRITE_STATUS = 8'h01;
   localparam logic [7:0] OP_WRITE_NV_CONFIG = 8'hB1;
   localparam logic [7:0] OP_WRITE_V_CONFIG = 8'h81;
   localparam logic [7:0] OP_WRITE_EV_CONFIG = 8'h61;
   localparam logic [7:0] OP_WRITE_EXT_ADDR = 8'hC5;
   localparam logic [7:0] OP_READ_STATUS = 8'h05;
   localparam logic [7:0] OP_READ_FLAGS = 8'h70;
   localparam logic [7:0] OP_READ_NV_CONFIG = 8'hB5;
   localparam logic [7:0] OP_READ_V_CONFIG = 8'h85;
   localparam logic [7:0] OP_READ_EV_CONFIG = 8'h65;
   localparam logic [7:0] OP_READ_EXT_ADDR = 8'hC8;
   // Field positions
   localparam int SR_WIP_BIT = 0;
   localparam int SR_WEL_BIT = 1;
   localparam int SR_PROTECT_BIT = 7;
   localparam int FSR_READY_BIT = 7;
   localparam int FSR_PROT_ERR_BIT = 1;
   localparam logic [7:0] FSR_ERROR_MASK = 8'h3A;
   localparam logic [7:0] SR_WRITE_MASK = 8'hFC;
   localparam logic [7:0] VCR_WRITE_MASK = 8'hFB;
   // Reset values
   localparam logic [7:0] SR_RESET = 8'h00;
   localparam logic [7:0] FSR_RESET = 8'h80;
   localparam logic [15:0] NVCR_RESET = 16'hFFFF;
   localparam logic [7:0] VCR_RESET = 8'hFB;
   localparam logic [7:0] EVCR_RESET = 8'hDF;
   localparam logic [7:0] EAR_RESET = 8'h00;
   // Frame lengths in bits
   localparam logic [4:0] BITS_OPCODE = 5'h08;
   localparam logic [4:0] BITS_ONE_BYTE = 5'h10;
   localparam logic [4:0] BITS_TWO_BYTES = 5'h18;
   localparam logic [5:0] BITS_SATURATE = 6'h1F;

   typedef enum logic [1:0] {MODE_EXTENDED, MODE_DUAL, MODE_QUAD} io_mode_t;

   typedef struct packed {
      logic [1:0] mode;
      logic [7:0] sr;
      logic [7:0] fsr;
      logic [15:0] nvcr;
      logic [7:0] vcr;
      logic [7:0] evcr;
      logic [7:0] ear;
   } reg_image_t;
endpackage

/* link_bus_if.sv */
// Signals between the system-clock core and the serial-clock shifter
`timescale 1ns/1ns
interface link_bus_if;
   flash_reg_pkg::reg_image_t image;
   logic link_reset;
   logic [4:0] rx_count;
   logic [23:0] rx_data;
   logic frame_toggle;
   modport sys (output image, output link_reset, input rx_count, input rx_data,
      input frame_toggle);
   modport link (input image, input link_reset, output rx_count, output rx_data,
      output frame_toggle);
endinterface

/* link_shifter.sv */
// Serial-clock shifter: collects command bits and shifts register reads out
`timescale 1ns/1ns
module link_shifter (
   // Link clock and frame
   input wire logic sclk,
   input wire logic cs_n,
   // Data lines
   input wire logic [3:0] dq_in,
   output logic [3:0] dq_out,
   output logic [3:0] dq_oe,
   // Toward the core
   link_bus_if.link bus
);
   typedef struct packed {
      logic [4:0] count;
      logic [23:0] shift;
      logic toggle;
      logic [15:0] tx;
      logic rotate;
      logic sending;
      logic [3:0] dq;
   } link_state_t;

   link_state_t state_reg, state_next;
   logic fresh_reg;
   logic [3:0] oe_reg, oe_next;

   assign bus.rx_count = state_reg.count;
   assign bus.rx_data = state_reg.shift;
   assign bus.frame_toggle = state_reg.toggle;
   assign dq_out = state_reg.dq;
   assign dq_oe = oe_reg;

   always_comb begin
      logic [5:0] sum;
      logic [4:0] base_count;
      logic [23:0] base_shift;
      logic [2:0] width;
      logic [3:0] lanes;
      sum = 6'h00;
      base_count = state_reg.count;
      base_shift = state_reg.shift;
      width = 3'h1;
      lanes = 4'h2;
      state_next = state_reg;
      oe_next = oe_reg;
      // Image is quasi-static: it settles in the select-high gap, and staging it
      // on the stopped serial clock would serve the previous frame's mode
      if (bus.image.mode == flash_reg_pkg::MODE_DUAL) begin
         width = 3'h2;
         lanes = 4'h3;
      end else if (bus.image.mode == flash_reg_pkg::MODE_QUAD) begin
         width = 3'h4;
         lanes = 4'hF;
      end
      if (fresh_reg) begin
         base_count = 5'h00;
         base_shift = 24'h000000;
         state_next.toggle = ~state_reg.toggle;
         state_next.sending = 1'b0;
      end
      // [RULE4] [RULE22] one, two or four lines, MSB first
      if (width == 3'h4) begin
         state_next.shift = {base_shift[19:0], dq_in};
      end else if (width == 3'h2) begin
         state_next.shift = {base_shift[21:0], dq_in[1:0]};
      end else begin
         state_next.shift = {base_shift[22:0], dq_in[0]};
      end
      sum = {1'b0, base_count} + {3'h0, width};
      state_next.count = (sum > flash_reg_pkg::BITS_SATURATE) ?
         flash_reg_pkg::BITS_SATURATE[4:0] : sum[4:0];
      if (base_count < flash_reg_pkg::BITS_OPCODE && state_next.count == flash_reg_pkg::BITS_OPCODE) begin
         state_next.sending = 1'b1;
         state_next.rotate = 1'b1;
         unique case (state_next.shift[7:0])
            flash_reg_pkg::OP_READ_STATUS: state_next.tx = {2{bus.image.sr}};
            // [RULE21] flag status served even while busy
            flash_reg_pkg::OP_READ_FLAGS: state_next.tx = {2{bus.image.fsr}};
            flash_reg_pkg::OP_READ_NV_CONFIG: begin
               // [RULE19] low byte leaves first, then high byte, then zeros
               state_next.tx = {bus.image.nvcr[7:0], bus.image.nvcr[15:8]};
               state_next.rotate = 1'b0;
            end
            flash_reg_pkg::OP_READ_V_CONFIG: state_next.tx = {2{bus.image.vcr}};
            flash_reg_pkg::OP_READ_EV_CONFIG: state_next.tx = {2{bus.image.evcr}};
            flash_reg_pkg::OP_READ_EXT_ADDR: state_next.tx = {2{bus.image.ear}};
            default: state_next.sending = 1'b0;
         endcase
         oe_next = state_next.sending ? lanes : 4'h0;
      end else if (state_reg.sending && !fresh_reg) begin
         // Byte registers rotate so a long read repeats the same byte
         if (width == 3'h4) begin
            state_next.tx = {state_reg.tx[11:0], state_reg.rotate ? state_reg.tx[15:12] : 4'h0};
         end else if (width == 3'h2) begin
            state_next.tx = {state_reg.tx[13:0], state_reg.rotate ? state_reg.tx[15:14] : 2'h0};
         end else begin
            state_next.tx = {state_reg.tx[14:0], state_reg.rotate ? state_reg.tx[15] : 1'b0};
         end
      end
      if (width == 3'h4) begin
         state_next.dq = state_next.tx[15:12];
      end else if (width == 3'h2) begin
         state_next.dq = {2'h0, state_next.tx[15:14]};
      end else begin
         state_next.dq = {2'h0, state_next.tx[15], 1'b0};
      end
   end

   always_ff @(posedge sclk or posedge bus.link_reset) begin
      if (bus.link_reset) begin
         state_reg <= '0;
      end else begin
         state_reg <= state_next;
      end
   end

   // Select high ends the frame at once, even with the clock stopped
   always_ff @(posedge sclk or posedge cs_n) begin
      if (cs_n) begin
         fresh_reg <= 1'b1;
         oe_reg <= 4'h0;
      end else begin
         fresh_reg <= 1'b0;
         oe_reg <= oe_next;
      end
   end
endmodule

/* flash_reg_write_chk.sv */
// Port assertions for the register-write block
`timescale 1ns/1ns
module flash_reg_write_chk #(
   parameter int STATUS_WRITE_CYCLES = 20,
   parameter int NV_CONFIG_WRITE_CYCLES = 30
) (
   // Clock, reset and pin
   input wire logic clock,
   input wire logic reset,
   input wire logic write_protect_n,
   // Register view
   input wire logic [7:0] status_reg,
   input wire logic [7:0] flag_status,
   input wire logic [15:0] nv_config,
   input wire logic write_busy,
   input wire logic hw_protected
);
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (reset);
   int unsigned busy_len_reg;
   // Counted here, a repetition this long would stall the tools
   always_ff @(posedge clock) begin
      busy_len_reg <= (reset || !write_busy) ? 0 : busy_len_reg + 1;
   end
   sequence s_start;
      $rose(write_busy);
   endsequence
   sequence s_done;
      $fell(write_busy);
   endsequence
   chk_busy_mirror: assert property (write_busy == status_reg[0])
      else $error("busy differs from status bit 0");
   chk_start_state: assert property (s_start |-> !status_reg[1] && !flag_status[7])
      else $error("timed write started with latch set or ready");
   chk_done_ready: assert property (s_done |-> flag_status[7] && !status_reg[1])
      else $error("timed write ended without ready");
   chk_busy_length: assert property (s_done |->
      busy_len_reg == STATUS_WRITE_CYCLES || busy_len_reg == NV_CONFIG_WRITE_CYCLES)
      else $error("timed write length wrong");
   chk_sr_frozen: assert property (write_busy && $past(write_busy)
      |-> $stable(status_reg[7:2]))
      else $error("status changed during timed write");
   chk_nv_hold: assert property (s_start |=> $stable(nv_config)[*8])
      else $error("nonvolatile value changed early");
   chk_prot_set: assert property ((!write_protect_n && status_reg[7])[*6]
      |-> hw_protected)
      else $error("protection not raised");
   chk_prot_clear: assert property (write_protect_n[*6] |-> !hw_protected)
      else $error("protection raised with pin high");
endmodule
bind flash_reg_write flash_reg_write_chk #(
   .STATUS_WRITE_CYCLES(STATUS_WRITE_CYCLES),
   .NV_CONFIG_WRITE_CYCLES(NV_CONFIG_WRITE_CYCLES)
) chk (
   .clock(clock), .reset(reset), .write_protect_n(write_protect_n),
   .status_reg(status_reg), .flag_status(flag_status), .nv_config(nv_config),
   .write_busy(write_busy), .hw_protected(hw_protected)
);

/* spi_host_model.sv */
// Host controller model driving the serial link
`timescale 1ns/1ns
module spi_host_model (
   // Link toward the device
   output logic sclk,
   output logic cs_n,
   output wire logic [3:0] dq_in,
   input wire logic [3:0] dq_out,
   input wire logic [3:0] dq_oe
);
   logic [3:0] drv;
   // Wire level: device drives the lanes its enable sets, host drives the rest
   assign dq_in = (dq_oe & dq_out) | (~dq_oe & drv);
   initial begin
      sclk = 1'b0;
      cs_n = 1'b1;
      drv = 4'h5;
   end
   // Clock stands still outside frames, 48 ns period within
   task automatic frame(input logic [23:0] w, input int nw, input int nr, input int ln,
      output logic [15:0] rd);
      rd = 16'h0000;
      cs_n = 1'b0;
      for (int b = 0; b < (nw + nr) / ln; b++) begin
         for (int l = ln - 1; l >= 0; l--) begin
            drv[l] = (b < nw / ln) ? w[23] : ~drv[l];
            w = w << 1;
         end
         #23;
         if (b >= nw / ln) begin
            rd = (ln == 1) ? {rd[14:0], dq_out[1]} :
               (rd << ln) | 16'(dq_out & ((4'h1 << ln) - 4'h1));
         end
         #1 sclk = 1'b1;
         #24 sclk = 1'b0;
      end
      #24 cs_n = 1'b1;
      drv = ~drv;
      #400;
   endtask
endmodule

/* flash_reg_write_bench.sv */
// Self-checking bench for the register-write block
`timescale 1ns/1ns
module flash_reg_write_bench;
   logic clock, reset, write_protect_n, write_busy, hw_protected;
   wire sclk, cs_n;
   wire [3:0] dq_in;
   logic [3:0] dq_out, dq_oe;
   logic [1:0] io_mode;
   logic [7:0] status_reg, flag_status, v_config, ev_config, ext_addr, d, sr, v_exp;
   logic [15:0] nv_config, rd, nv_exp;
   logic [19:0] notes[$];
   logic [19:0] n;
   logic [31:0] seed;
   int miscompares = 0, checks = 0, cycles = 0;
   event take;
   wire [127:0] obs = {15'h0000, hw_protected, rd, 8'h00, ext_addr, 8'h00, ev_config,
      8'h00, v_config, nv_config, 8'h00, flag_status, 8'h00, status_reg};
   flash_reg_write #(.STATUS_WRITE_CYCLES(200), .NV_CONFIG_WRITE_CYCLES(300)) dut (
      .clock(clock), .reset(reset), .sclk(sclk), .cs_n(cs_n), .dq_in(dq_in),
      .dq_out(dq_out), .dq_oe(dq_oe), .write_protect_n(write_protect_n),
      .io_mode(io_mode), .status_reg(status_reg), .flag_status(flag_status),
      .nv_config(nv_config), .v_config(v_config), .ev_config(ev_config),
      .ext_addr(ext_addr), .write_busy(write_busy), .hw_protected(hw_protected));
   spi_host_model host (.sclk(sclk), .cs_n(cs_n), .dq_in(dq_in), .dq_out(dq_out),
      .dq_oe(dq_oe));
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic wrap_up();
      $display("checks=%0d miscompares=%0d", checks, miscompares);
      if (miscompares == 0 && checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask
   // Sampled mid-cycle so register updates have landed
   task automatic note(input logic [3:0] k, input logic [15:0] e);
      @(negedge clock);
      notes.push_back({k, e});
      -> take;
   endtask
   task automatic cmd(input logic [7:0] op, input logic [15:0] dat, input int nd,
      input int nr);
      host.frame({op, dat}, 8 + nd, nr, 1 << io_mode, rd);
   endtask
   // write enable before each register write except the retried status write
   task automatic wen();
      cmd(8'h06, 16'h0000, 0, 0);
   endtask
   task automatic wait_idle();
      for (int i = 0; i < 400 && write_busy !== 1'b0; i++) @(negedge clock);
   endtask
   initial begin
      forever begin
         @(take);
         n = notes.pop_front();
         check(obs[n[19:16] * 16 +: 16], n[15:0]);
      end
   end
   initial begin
      clock = 1'b0;
      forever #20 clock = ~clock;
   end
   always @(posedge clock) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         miscompares++;
         wrap_up();
      end
   end
   initial begin
      reset = 1'b1;
      io_mode = 2'h0;
      write_protect_n = 1'b1;
      seed = 32'h9ED30A7D;
      sr = 8'h00;
      v_exp = flash_reg_pkg::VCR_RESET;
      nv_exp = flash_reg_pkg::NVCR_RESET;
      repeat (16) @(posedge clock);
      reset <= 1'b0;
      repeat (4) @(posedge clock);
      for (int m = 0; m < 3; m++) begin
         io_mode <= 2'(m);
         @(posedge clock);
         seed = lfsr(seed);
         d = seed[7:0] & 8'h7F;
         wen();
         note(4'h0, {8'h00, sr | 8'h02});
         cmd(8'h01, {d, 8'h00}, 4, 0);
         note(4'h0, {8'h00, sr | 8'h02});
         note(4'h1, 16'h0080);
         cmd(8'h01, {d, 8'h00}, 8, 0);
         note(4'h0, {8'h00, d[7:2], 2'b01});
         note(4'h1, 16'h0000);
         cmd(8'h70, 16'h0000, 0, 8);
         note(4'h6, 16'h0000);
         wen();
         note(4'h0, {8'h00, d[7:2], 2'b01});
         wait_idle();
         sr = {d[7:2], 2'b00};
         note(4'h0, {8'h00, sr});
         note(4'h1, 16'h0080);
         wen();
         cmd(8'hB1, seed[23:8], 16, 0);
         note(4'h2, nv_exp);
         wait_idle();
         nv_exp = {seed[15:8], seed[23:16]};
         note(4'h2, nv_exp);
         cmd(8'hB5, 16'h0000, 0, 16);
         note(4'h6, {nv_exp[7:0], nv_exp[15:8]});
         wen();
         cmd(8'h81, {seed[31:24], 8'h00}, 8, 0);
         v_exp = (seed[31:24] & flash_reg_pkg::VCR_WRITE_MASK) |
            (v_exp & ~flash_reg_pkg::VCR_WRITE_MASK);
         note(4'h3, {8'h00, v_exp});
         cmd(8'h85, 16'h0000, 0, 8);
         note(4'h6, {8'h00, v_exp});
         wen();
         cmd(8'h61, {seed[15:8], 8'h00}, 8, 0);
         note(4'h4, {8'h00, seed[15:8]});
         wen();
         cmd(8'hC5, {seed[23:16], 8'h00}, 8, 0);
         note(4'h5, {8'h00, seed[23:16]});
      end
      wen();
      cmd(8'h01, 16'h8000, 8, 0);
      wait_idle();
      @(posedge clock) write_protect_n <= 1'b0;
      repeat (8) @(posedge clock);
      note(4'h7, 16'h0001);
      wen();
      cmd(8'h01, 16'h0000, 8, 0);
      note(4'h1, 16'h0082);
      note(4'h0, 16'h0082);
      wrap_up();
   end
endmodule
